/* File: common/stripe_test_pkg.sv */
/*
  Shared constants and types of the stripe test pattern generator and checker:
  register map, control bit positions, pattern and state encodings, bus carriers.
  Assumes a 32-bit APB master and one user clock common to both FIFOs.
*/
package stripe_test_pkg;

  // ----------------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------------
  localparam int DATA_W = 512;
  localparam int DWORDS = 16;
  localparam int BLOCK_WORDS_LOG2 = 3;
  localparam int LFSR_LANES = 4;
  localparam int LFSR_SETS = 2;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int APB_ADDR_W = 8;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PATTERN = 8'h04;
  localparam logic [7:0] OFS_END_SIZE = 8'h08;
  localparam logic [7:0] OFS_START_ADDR = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_WORD_COUNT = 8'h14;
  localparam logic [7:0] OFS_BLOCK_ADDR = 8'h18;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DIR_WRITE_BIT = 1;
  localparam int CTRL_VERIFY_BIT = 2;
  localparam int CTRL_CLEAR_BIT = 3;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_FAIL_BIT = 1;
  localparam int STAT_PULSE_BIT = 2;

  localparam logic [31:0] END_SIZE_RESET = 32'h0000_0000;
  localparam logic [31:0] START_ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] HEADER_HIGH = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PAT_ZEROS = 3'h0,
    PAT_ONES = 3'h1,
    PAT_INCR = 3'h2,
    PAT_DECR = 3'h3,
    PAT_LFSR = 3'h4
  } pattern_t;

  typedef enum logic [2:0] {
    FSM_IDLE = 3'b001,
    FSM_START = 3'b010,
    FSM_WRITE = 3'b100
  } fsm_t;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    fsm_t fsm;
    logic dir_write;
    logic verify_en;
    pattern_t pattern;
    logic [31:0] end_size_limit;
    logic [31:0] start_addr;
    logic [31:0] transfer_word_counter;
    logic [31:0] block_address_counter;
    logic [LFSR_SETS-1:0][31:0] lfsr;
    logic [DATA_W-1:0] tx_data;
    logic write_strobe_reg;
    logic fail;
    logic ack;
    logic [31:0] prdata;
  } state_t;

endpackage

/* File: hdl/stripe_test_pattern_checker.sv */
/*
  Test pattern generator and checker: streams 512-bit words into the outgoing
  FIFO and checks 512-bit words taken from the incoming FIFO, set up over APB.
  Assumes the FIFOs run on mclk_in, the incoming FIFO shows its head word on
  rx_fifo_data_in while not empty (first-word fall-through), and the outgoing
  FIFO leaves room for one more word after raising its almost-full flag.
*/
module stripe_test_pattern_checker (
  input wire logic mclk_in, // user clock, 40 MHz
  input wire logic reset_n_in, // asynchronous reset, active low
  input wire stripe_test_pkg::apb_req_t apb_in, // apb request from master
  output stripe_test_pkg::apb_rsp_t apb_out, // apb answer to master
  input wire logic tx_fifo_almost_full_flag_in, // outgoing fifo almost full
  output logic tx_fifo_write_strobe_out, // outgoing fifo write enable
  output logic [stripe_test_pkg::DATA_W-1:0] tx_fifo_data_out, // outgoing word
  input wire logic rx_fifo_empty_flag_in, // incoming fifo empty
  output logic rx_fifo_read_strobe_out, // incoming fifo read enable
  input wire logic [stripe_test_pkg::DATA_W-1:0] rx_fifo_data_in, // incoming word
  output logic write_start_pulse_out, // one clock at write run start
  output logic write_active_flag_out, // write run in progress
  output logic fail_flag_out // sticky verify failure
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  stripe_test_pkg::state_t s_q;
  stripe_test_pkg::state_t s_d;

  // ----------------------------------------------------------------------
  // lfsr step, one shift of the x^31 + x^21 + x + 1 sequence
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    lfsr_step = {v[30:0], v[30] ^ v[20] ^ v[0]};
  endfunction

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic access;
  logic wr_take;
  logic mapped;
  logic ctrl_write;
  logic start_cmd;
  logic clear_cmd;

  assign access = apb_in.psel && apb_in.penable;
  // one wait state: data is fetched into a flop, then pready rises
  assign wr_take = access && s_q.ack && apb_in.pwrite;
  assign ctrl_write = wr_take && (apb_in.paddr == stripe_test_pkg::OFS_CONTROL);
  assign clear_cmd = ctrl_write && apb_in.pwdata[stripe_test_pkg::CTRL_CLEAR_BIT];
  // a start during a running write is ignored, not queued
  assign start_cmd = ctrl_write && !clear_cmd
    && apb_in.pwdata[stripe_test_pkg::CTRL_START_BIT]
    && (s_q.fsm == stripe_test_pkg::FSM_IDLE);

  always_comb begin
    unique case (apb_in.paddr)
      stripe_test_pkg::OFS_CONTROL,
      stripe_test_pkg::OFS_PATTERN,
      stripe_test_pkg::OFS_END_SIZE,
      stripe_test_pkg::OFS_START_ADDR,
      stripe_test_pkg::OFS_STATUS,
      stripe_test_pkg::OFS_WORD_COUNT,
      stripe_test_pkg::OFS_BLOCK_ADDR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // flow control
  // ----------------------------------------------------------------------
  logic at_end;
  logic wr_adv;
  logic rd_adv;
  logic adv;
  logic block_first;
  logic block_last;

  assign at_end = (s_q.transfer_word_counter == s_q.end_size_limit);
  assign wr_adv = (s_q.fsm == stripe_test_pkg::FSM_WRITE)
    && !tx_fifo_almost_full_flag_in
    && !at_end && !clear_cmd;
  // draining never waits for a start nor stops at the end size
  assign rx_fifo_read_strobe_out = !rx_fifo_empty_flag_in && !clear_cmd;
  assign rd_adv = rx_fifo_read_strobe_out && !s_q.dir_write;
  assign adv = wr_adv || rd_adv;
  assign block_first = (s_q.transfer_word_counter[stripe_test_pkg::BLOCK_WORDS_LOG2-1:0] == '0);
  assign block_last = (s_q.transfer_word_counter[stripe_test_pkg::BLOCK_WORDS_LOG2-1:0] == '1);

  // ----------------------------------------------------------------------
  // lfsr look-ahead
  // ----------------------------------------------------------------------
  logic [31:0] seed_addr;
  logic [31:0] seed_addr_inv;
  logic [stripe_test_pkg::LFSR_SETS-1:0][31:0] seed;
  logic [stripe_test_pkg::LFSR_SETS-1:0][stripe_test_pkg::LFSR_LANES-1:0][31:0] lane;
  logic [stripe_test_pkg::LFSR_SETS-1:0][31:0] lfsr_next;

  assign seed_addr = s_q.block_address_counter;
  assign seed_addr_inv = ~s_q.block_address_counter;
  // each block restarts from its own address so any block can be checked alone
  assign seed[0] = {seed_addr[31:16], seed_addr_inv[15:0]};
  assign seed[1] = {seed_addr_inv[31:16], seed_addr[15:0]};

  genvar gs;
  genvar gl;
  generate
    for (gs = 0; gs < stripe_test_pkg::LFSR_SETS; gs++) begin : g_set
      assign lane[gs][0] = block_first ? seed[gs] : s_q.lfsr[gs];
      for (gl = 1; gl < stripe_test_pkg::LFSR_LANES; gl++) begin : g_lane
        assign lane[gs][gl] = lfsr_step(lane[gs][gl-1]);
      end
      assign lfsr_next[gs] = lfsr_step(lane[gs][stripe_test_pkg::LFSR_LANES-1]);
    end
  endgenerate

  // ----------------------------------------------------------------------
  // pattern generator, shared by both directions
  // ----------------------------------------------------------------------
  logic [stripe_test_pkg::DATA_W-1:0] gen_word;
  logic counted;

  assign counted = (s_q.pattern == stripe_test_pkg::PAT_INCR)
    || (s_q.pattern == stripe_test_pkg::PAT_DECR)
    || (s_q.pattern == stripe_test_pkg::PAT_LFSR);

  genvar gd;
  generate
    for (gd = 0; gd < stripe_test_pkg::DWORDS; gd++) begin : g_dw
      logic [31:0] incr;
      logic [31:0] body;
      logic [31:0] head;
      assign incr = {s_q.transfer_word_counter[27:0], 4'(gd)};
      assign head = (gd == 0) ? s_q.block_address_counter : stripe_test_pkg::HEADER_HIGH;
      always_comb begin
        unique case (s_q.pattern)
          stripe_test_pkg::PAT_ONES: body = 32'hFFFF_FFFF;
          stripe_test_pkg::PAT_INCR: body = incr;
          stripe_test_pkg::PAT_DECR: body = ~incr;
          stripe_test_pkg::PAT_LFSR: body = lane[(gd / 4) % 2][gd % 4];
          default: body = 32'h0000_0000;
        endcase
      end
      // in incr, decr and lfsr patterns the header occupies dwords 0 and 1 of the first word of each block
      assign gen_word[gd*32 +: 32] = (counted && block_first && gd < 2) ? head : body;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // checker
  // ----------------------------------------------------------------------
  logic mismatch;

  // compare is skipped with verify off, but the fifo keeps draining
  assign mismatch = rd_adv && s_q.verify_en && (rx_fifo_data_in != gen_word);

  // ----------------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (apb_in.paddr)
      stripe_test_pkg::OFS_CONTROL: begin
        rd_mux[stripe_test_pkg::CTRL_DIR_WRITE_BIT] = s_q.dir_write;
        rd_mux[stripe_test_pkg::CTRL_VERIFY_BIT] = s_q.verify_en;
      end
      stripe_test_pkg::OFS_PATTERN: rd_mux[2:0] = s_q.pattern;
      stripe_test_pkg::OFS_END_SIZE: rd_mux = s_q.end_size_limit;
      stripe_test_pkg::OFS_START_ADDR: rd_mux = s_q.start_addr;
      stripe_test_pkg::OFS_STATUS: begin
        rd_mux[stripe_test_pkg::STAT_ACTIVE_BIT] = (s_q.fsm == stripe_test_pkg::FSM_WRITE);
        rd_mux[stripe_test_pkg::STAT_FAIL_BIT] = s_q.fail;
        rd_mux[stripe_test_pkg::STAT_PULSE_BIT] = (s_q.fsm == stripe_test_pkg::FSM_START);
      end
      stripe_test_pkg::OFS_WORD_COUNT: rd_mux = s_q.transfer_word_counter;
      stripe_test_pkg::OFS_BLOCK_ADDR: rd_mux = s_q.block_address_counter;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.write_strobe_reg = 1'b0;
    s_d.ack = access && !s_q.ack;
    if (access && !s_q.ack) begin
      s_d.prdata = apb_in.pwrite ? 32'h0000_0000 : rd_mux;
    end

    // register writes
    if (wr_take) begin
      unique case (apb_in.paddr)
        stripe_test_pkg::OFS_CONTROL: begin
          s_d.dir_write = apb_in.pwdata[stripe_test_pkg::CTRL_DIR_WRITE_BIT];
          s_d.verify_en = apb_in.pwdata[stripe_test_pkg::CTRL_VERIFY_BIT];
        end
        stripe_test_pkg::OFS_PATTERN: begin
          s_d.pattern = stripe_test_pkg::pattern_t'(apb_in.pwdata[2:0]);
        end
        stripe_test_pkg::OFS_END_SIZE: s_d.end_size_limit = apb_in.pwdata;
        stripe_test_pkg::OFS_START_ADDR: s_d.start_addr = apb_in.pwdata;
        default: s_d.prdata = s_q.prdata;
      endcase
    end

    // run control
    unique case (s_q.fsm)
      stripe_test_pkg::FSM_IDLE: begin
        if (start_cmd && apb_in.pwdata[stripe_test_pkg::CTRL_DIR_WRITE_BIT]) begin
          s_d.fsm = stripe_test_pkg::FSM_START;
        end
      end
      stripe_test_pkg::FSM_START: s_d.fsm = stripe_test_pkg::FSM_WRITE;
      stripe_test_pkg::FSM_WRITE: begin
        if (at_end) begin
          s_d.fsm = stripe_test_pkg::FSM_IDLE;
        end
      end
      default: s_d.fsm = stripe_test_pkg::FSM_IDLE;
    endcase

    // counters and generator state
    if (start_cmd) begin
      s_d.transfer_word_counter = 32'h0000_0000;
      s_d.block_address_counter = s_q.start_addr;
      s_d.fail = 1'b0;
    end else if (adv) begin
      s_d.transfer_word_counter = s_q.transfer_word_counter + 32'h0000_0001;
      s_d.lfsr = lfsr_next;
      if (block_last) begin
        s_d.block_address_counter = s_q.block_address_counter + 32'h0000_0001;
      end
    end

    // registered write data from the shared generator
    if (wr_adv) begin
      s_d.write_strobe_reg = 1'b1;
      s_d.tx_data = gen_word;
    end

    if (clear_cmd) begin
      s_d.fsm = stripe_test_pkg::FSM_IDLE;
      s_d.transfer_word_counter = 32'h0000_0000;
      s_d.block_address_counter = 32'h0000_0000;
      s_d.fail = 1'b0;
    end

    // no mismatch arises in the clearing cycle, as the read strobe is held low then
    if (mismatch) begin
      s_d.fail = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
      s_q.fsm <= stripe_test_pkg::FSM_IDLE;
      s_q.pattern <= stripe_test_pkg::PAT_ZEROS;
      s_q.end_size_limit <= stripe_test_pkg::END_SIZE_RESET;
      s_q.start_addr <= stripe_test_pkg::START_ADDR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign apb_out.prdata = s_q.prdata;
  assign apb_out.pready = access && s_q.ack;
  assign apb_out.pslverr = access && s_q.ack && !mapped;
  assign tx_fifo_write_strobe_out = s_q.write_strobe_reg;
  assign tx_fifo_data_out = s_q.tx_data;
  assign write_start_pulse_out = (s_q.fsm == stripe_test_pkg::FSM_START);
  assign write_active_flag_out = (s_q.fsm == stripe_test_pkg::FSM_WRITE);
  assign fail_flag_out = s_q.fail;

endmodule

/* File: bench/stripe_fifo_model.sv */
/* Behavioural pair of FIFOs standing on the storage side of the pattern checker.
   Assumes the bench pushes incoming words into rx_q and reads captured words from tx_q. */
module stripe_fifo_model (
  input wire logic mclk_in, // shared user clock
  input wire logic stall_in, // slow both fifos down
  input wire logic wr_strobe_in, // outgoing write enable
  input wire logic [stripe_test_pkg::DATA_W-1:0] wr_data_in, // outgoing word
  output logic almost_full_out, // outgoing fifo almost full
  input wire logic rd_strobe_in, // incoming read enable
  output logic empty_out, // incoming fifo empty
  output logic [stripe_test_pkg::DATA_W-1:0] rd_data_out // incoming head word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [stripe_test_pkg::DATA_W-1:0] tx_q[$];
  logic [stripe_test_pkg::DATA_W-1:0] rx_q[$];
  logic gap;
  int cyc = 0;
  initial begin
    almost_full_out = 1'b0;
    empty_out = 1'b1;
    rd_data_out = '0;
  end
  // ----
  // fifo behaviour
  // ----
  always @(posedge mclk_in) begin
    cyc++;
    if (wr_strobe_in) begin
      tx_q.push_back(wr_data_in);
    end
    if (rd_strobe_in && !empty_out) begin
      void'(rx_q.pop_front());
    end
    gap = stall_in && (cyc % 5 == 0);
    almost_full_out <= stall_in && (cyc % 7 >= 4);
    empty_out <= gap || rx_q.size() == 0;
    // no word on offer: show a changing value so stale data never matches
    rd_data_out <= (gap || rx_q.size() == 0) ? ~rd_data_out : rx_q[0];
  end
endmodule

/* File: bench/stripe_test_pattern_checker_sva.sv */
/* Port checker for the stripe test pattern checker.
   Assumes one clock and an asynchronous active-low reset; bound into the design. */
module stripe_test_pattern_checker_sva (
  input wire logic mclk_in, // user clock
  input wire logic reset_n_in, // reset, active low
  input wire stripe_test_pkg::apb_req_t apb_in, // apb request
  input wire stripe_test_pkg::apb_rsp_t apb_out, // apb answer
  input wire logic tx_fifo_almost_full_flag_in, // tx almost full
  input wire logic tx_fifo_write_strobe_out, // tx write enable
  input wire logic [stripe_test_pkg::DATA_W-1:0] tx_fifo_data_out, // tx word
  input wire logic rx_fifo_empty_flag_in, // rx empty
  input wire logic rx_fifo_read_strobe_out, // rx read enable
  input wire logic write_start_pulse_out, // start pulse
  input wire logic write_active_flag_out, // write run active
  input wire logic fail_flag_out // sticky fail
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_done;
  logic [31:0] end_q;
  logic [31:0] strobes_q;
  // ----
  // helpers
  // ----
  assign wr_done = apb_in.psel && apb_in.penable && apb_out.pready && apb_in.pwrite;
  // end size is mirrored from the bus since no port shows it
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      end_q <= 32'h0000_0000;
      strobes_q <= 32'h0000_0000;
    end else begin
      if (wr_done && apb_in.paddr == stripe_test_pkg::OFS_END_SIZE) begin
        end_q <= apb_in.pwdata;
      end
      strobes_q <= write_start_pulse_out ? 32'h0000_0000 :
                   strobes_q + {31'h0000_0000, tx_fifo_write_strobe_out};
    end
  end
  // ----
  // checks
  // ----
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);
  sequence access_begin_s;
    apb_in.psel && $rose(apb_in.penable);
  endsequence
  sequence run_start_s;
    write_start_pulse_out ##1 write_active_flag_out && !write_start_pulse_out;
  endsequence
  apb_one_wait_a: assert property (access_begin_s |-> !apb_out.pready ##1 apb_out.pready)
    else $error("apb wait state wrong");
  apb_unmapped_a: assert property (apb_out.pready &&
    apb_in.paddr > stripe_test_pkg::OFS_BLOCK_ADDR |-> apb_out.pslverr)
    else $error("unmapped access not refused");
  start_pulse_a: assert property (wr_done && apb_in.paddr == stripe_test_pkg::OFS_CONTROL &&
    apb_in.pwdata[1:0] == 2'b11 && !write_start_pulse_out && !write_active_flag_out
    |=> run_start_s) else $error("start pulse or active flag wrong");
  strobe_when_active_a: assert property (tx_fifo_write_strobe_out |->
    $past(write_active_flag_out)) else $error("write strobe outside a run");
  full_pauses_a: assert property (tx_fifo_almost_full_flag_in |=> !tx_fifo_write_strobe_out)
    else $error("write strobe while almost full");
  // the last strobe stands in the cycle before active falls, already counted in strobes_q
  run_length_a: assert property ($fell(write_active_flag_out) |->
    strobes_q + {31'h0000_0000, tx_fifo_write_strobe_out} == end_q)
    else $error("run length differs from end size");
  read_follows_empty_a: assert property (!(wr_done && apb_in.pwdata[3] &&
    apb_in.paddr == stripe_test_pkg::OFS_CONTROL)
    |-> rx_fifo_read_strobe_out == !rx_fifo_empty_flag_in) else $error("read strobe wrong");
  fail_needs_read_a: assert property ($rose(fail_flag_out) |-> $past(rx_fifo_read_strobe_out))
    else $error("fail without a read");
  word_holds_a: assert property (!tx_fifo_write_strobe_out |-> $stable(tx_fifo_data_out))
    else $error("tx word changed without strobe");
endmodule
bind stripe_test_pattern_checker stripe_test_pattern_checker_sva i_stripe_test_pattern_checker_sva (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .apb_in(apb_in), .apb_out(apb_out),
  .tx_fifo_almost_full_flag_in(tx_fifo_almost_full_flag_in),
  .tx_fifo_write_strobe_out(tx_fifo_write_strobe_out), .tx_fifo_data_out(tx_fifo_data_out),
  .rx_fifo_empty_flag_in(rx_fifo_empty_flag_in), .rx_fifo_read_strobe_out(rx_fifo_read_strobe_out),
  .write_start_pulse_out(write_start_pulse_out), .write_active_flag_out(write_active_flag_out),
  .fail_flag_out(fail_flag_out));

/* File: bench/stripe_test_pattern_checker_bench.sv */
/* Self-checking bench of the stripe test pattern checker.
   Assumes the fifo model beside it and the bound port checker. */
module stripe_test_pattern_checker_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic stall_q = 1'b0;
  stripe_test_pkg::apb_req_t apb_q = '0;
  stripe_test_pkg::apb_rsp_t apb_rsp;
  logic af, tx_stb, rx_empty, rx_stb, pulse, active, fail, err_q;
  logic [511:0] tx_data, rx_data;
  logic [31:0] rd_q;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  stripe_test_pattern_checker i_stripe_test_pattern_checker (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .apb_in(apb_q), .apb_out(apb_rsp),
    .tx_fifo_almost_full_flag_in(af), .tx_fifo_write_strobe_out(tx_stb),
    .tx_fifo_data_out(tx_data), .rx_fifo_empty_flag_in(rx_empty),
    .rx_fifo_read_strobe_out(rx_stb), .rx_fifo_data_in(rx_data),
    .write_start_pulse_out(pulse), .write_active_flag_out(active), .fail_flag_out(fail));
  stripe_fifo_model i_stripe_fifo_model (
    .mclk_in(mclk_in), .stall_in(stall_q), .wr_strobe_in(tx_stb), .wr_data_in(tx_data),
    .almost_full_out(af), .rd_strobe_in(rx_stb), .empty_out(rx_empty), .rd_data_out(rx_data));
  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  // ----
  // helpers
  // ----
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic check(input logic [511:0] seen, input logic [511:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge mclk_in);
    apb_q <= {1'b1, 1'b0, wr, addr, wdata};
    @(posedge mclk_in);
    apb_q.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    // a bus that never answers is a failure, not a silent skip
    if (apb_rsp.pready !== 1'b1) begin
      mismatches++;
    end
    rd_q = apb_rsp.prdata;
    err_q = apb_rsp.pslverr;
    apb_q <= '0;
  endtask
  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    check(rd_q, exp);
  endtask
  function automatic logic [511:0] exp_word(input logic [2:0] pat, input logic [31:0] n,
      input logic [31:0] a);
    logic [511:0] w;
    logic [31:0] v;
    for (int i = 0; i < 16; i++) begin
      v = i[2] ? {~a[31:16], a[15:0]} : {a[31:16], ~a[15:0]};
      for (int j = 0; j < 4 * n[2:0] + i[1:0]; j++) begin
        v = {v[30:0], v[30] ^ v[20] ^ v[0]};
      end
      case (pat)
        3'h1: w[32*i +: 32] = 32'hFFFF_FFFF;
        3'h2: w[32*i +: 32] = {n[27:0], i[3:0]};
        3'h3: w[32*i +: 32] = ~{n[27:0], i[3:0]};
        3'h4: w[32*i +: 32] = v;
        default: w[32*i +: 32] = 32'h0000_0000;
      endcase
    end
    if (pat inside {3'h2, 3'h3, 3'h4} && n[2:0] == 3'h0) w[63:0] = {32'h0000_0000, a};
    return w;
  endfunction
  // ----
  // runs
  // ----
  task automatic wr_run(input logic [2:0] pat, input logic [31:0] len, input logic [31:0] a0);
    int n;
    apb(1'b1, stripe_test_pkg::OFS_PATTERN, {29'h0000_0000, pat});
    apb(1'b1, stripe_test_pkg::OFS_END_SIZE, len);
    apb(1'b1, stripe_test_pkg::OFS_START_ADDR, a0);
    apb(1'b1, stripe_test_pkg::OFS_CONTROL, 32'h0000_0007);
    @(posedge mclk_in);
    check(pulse, 1'b1);
    @(posedge mclk_in);
    check({pulse, active}, 2'b01);
    n = 0;
    while (active === 1'b1 && n < 200) begin
      @(posedge mclk_in);
      n++;
    end
    check(i_stripe_fifo_model.tx_q.size(), len);
    foreach (i_stripe_fifo_model.tx_q[k]) begin
      check(i_stripe_fifo_model.tx_q[k], exp_word(pat, k, a0 + k / 8));
    end
    i_stripe_fifo_model.tx_q.delete();
    rd(stripe_test_pkg::OFS_WORD_COUNT, len);
    rd(stripe_test_pkg::OFS_BLOCK_ADDR, a0 + len / 8);
  endtask
  task automatic rd_run(input logic [2:0] pat, input logic [31:0] ctl, input int bad,
      input logic bad_fail);
    logic [511:0] w;
    int n;
    apb(1'b1, stripe_test_pkg::OFS_PATTERN, {29'h0000_0000, pat});
    apb(1'b1, stripe_test_pkg::OFS_START_ADDR, 32'hFFFF_FFFE);
    apb(1'b1, stripe_test_pkg::OFS_CONTROL, ctl);
    for (int k = 0; k < 12; k++) begin
      w = exp_word(pat, k, 32'hFFFF_FFFE + k / 8);
      w[511] = w[511] ^ (k == bad);
      i_stripe_fifo_model.rx_q.push_back(w);
    end
    n = 0;
    while (i_stripe_fifo_model.rx_q.size() > 0 && n < 200) begin
      @(posedge mclk_in);
      n++;
    end
    repeat (2) @(posedge mclk_in);
    check(fail, bad_fail);
    rd(stripe_test_pkg::OFS_WORD_COUNT, 32'h0000_000C);
    rd(stripe_test_pkg::OFS_BLOCK_ADDR, 32'hFFFF_FFFF);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (8) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    @(posedge mclk_in);
    check({active, tx_stb, pulse, fail}, 4'h0);
    rd(stripe_test_pkg::OFS_END_SIZE, stripe_test_pkg::END_SIZE_RESET);
    apb(1'b1, stripe_test_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    rd(stripe_test_pkg::OFS_STATUS, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    check({err_q, rd_q}, {1'b1, 32'h0000_0000});
    for (int p = 0; p < 6; p++) begin
      stall_q <= p[0];
      wr_run(p[2:0], 32'h0000_000A, 32'h1234_5670 + p);
    end
    wr_run(3'h2, 32'h0000_0000, 32'h0000_0009);
    stall_q <= 1'b1;
    rd_run(3'h4, 32'h0000_0005, 99, 1'b0);
    rd_run(3'h3, 32'h0000_0005, 11, 1'b1);
    apb(1'b1, stripe_test_pkg::OFS_CONTROL, 32'h0000_0008);
    @(posedge mclk_in);
    check(fail, 1'b0);
    rd(stripe_test_pkg::OFS_WORD_COUNT, 32'h0000_0000);
    rd_run(3'h2, 32'h0000_0001, 3, 1'b0);
    conclude();
  end
endmodule
